// [verilog/tmc_top.sv]
// Purpose: 16-bit timer counter with buffered modulo and coherent byte reads over APB
// Assumes: inputs synchronous to REF_CLK_I; TIMER_TICK_I is a one-cycle tick
// Notes: APB answers with no wait state; read data is registered in the setup cycle
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "tmc_defines.svh"
module tmc_top (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // timer events and state
   input wire logic TIMER_TICK_I,
   input wire logic HALTED_DEBUG_STATE_I,
   output tmc_pkg::tmc_word_t COUNT_O,
   output logic WRAP_FLAG_O
);
   import tmc_pkg::*;

   tmc_if link ();

   // bus phase decode
   logic setup;
   logic access;
   logic wr_en;
   logic rd_en;
   logic hit_sc;
   logic hit_cnt_hi;
   logic hit_cnt_lo;
   logic hit_mod_hi;
   logic hit_mod_lo;
   logic mapped;

   // software visible state
   tmc_clksel_t clock_source_select;
   logic wrap_flag;
   tmc_coh_t coh;
   tmc_byte_t cnt_lat;
   tmc_word_t snap;
   logic [31:0] next_prdata;
   logic next_err;
   logic err_q;

   // leaf instances
   tmc_counter u_counter (
      .clk_i (REF_CLK_I),
      .srst_i (SRST_I),
      .bus (link.cnt)
   );

   tmc_modbuf u_modbuf (
      .clk_i (REF_CLK_I),
      .srst_i (SRST_I),
      .bus (link.modb)
   );

   // apb phases; writes and read side effects happen only in the access cycle
   assign setup = PSEL_I && !PENABLE_I;
   assign access = PSEL_I && PENABLE_I;
   assign wr_en = access && PWRITE_I;
   assign rd_en = access && !PWRITE_I;

   // address decode
   always_comb begin
      hit_sc = 1'b0;
      hit_cnt_hi = 1'b0;
      hit_cnt_lo = 1'b0;
      hit_mod_hi = 1'b0;
      hit_mod_lo = 1'b0;
      if (PADDR_I == `TMC_OFF_SC) begin
         hit_sc = 1'b1;
      end else if (PADDR_I == `TMC_OFF_CNT_HI) begin
         hit_cnt_hi = 1'b1;
      end else if (PADDR_I == `TMC_OFF_CNT_LO) begin
         hit_cnt_lo = 1'b1;
      end else if (PADDR_I == `TMC_OFF_MOD_HI) begin
         hit_mod_hi = 1'b1;
      end else if (PADDR_I == `TMC_OFF_MOD_LO) begin
         hit_mod_lo = 1'b1;
      end
   end

   assign mapped = hit_sc || hit_cnt_hi || hit_cnt_lo || hit_mod_hi || hit_mod_lo;

   // zero wait states; error is flagged for unmapped addresses only
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access && err_q;

   // drive the carrier toward the leaves
   assign link.step = TIMER_TICK_I && (clock_source_select != TMC_CLK_OFF)
                      && !HALTED_DEBUG_STATE_I;
   assign link.cnt_clear = wr_en && (hit_cnt_hi || hit_cnt_lo) && !HALTED_DEBUG_STATE_I;
   assign link.wr_hi = wr_en && hit_mod_hi;
   assign link.wr_lo = wr_en && hit_mod_lo;
   assign link.wdata = PWDATA_I[7:0];
   assign link.sc_wr = wr_en && hit_sc;
   assign link.debug = HALTED_DEBUG_STATE_I;
   assign link.clk_on = (clock_source_select != TMC_CLK_OFF);

   // clock source select, written through the status register
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         clock_source_select <= TMC_CLK_OFF;
      end else if (link.sc_wr) begin
         clock_source_select <= tmc_clksel_t'(PWDATA_I[`TMC_SC_CLK_HI:`TMC_SC_CLK_LO]);
      end
   end

   // wrap flag: writing zero to it clears, a wrap in the same cycle wins
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         wrap_flag <= 1'b0;
      end else if (link.wrap_evt && !link.inhibit) begin
         wrap_flag <= 1'b1;
      end else if (link.sc_wr && !PWDATA_I[`TMC_SC_WRAP_BIT]) begin
         wrap_flag <= 1'b0;
      end
   end

   // snapshot of the counter taken with the read data in the setup cycle
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         snap <= `TMC_CNT_RESET;
      end else if (setup) begin
         snap <= link.count;
      end
   end

   // read coherency: high read latches the low byte for the following low read
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         coh <= TMC_COH_IDLE;
      end else if (HALTED_DEBUG_STATE_I) begin
         if (link.sc_wr || (wr_en && (hit_cnt_hi || hit_cnt_lo))) begin
            coh <= TMC_COH_IDLE;
         end else begin
            coh <= coh;
         end
      end else if (link.sc_wr || link.cnt_clear) begin
         coh <= TMC_COH_IDLE;
      end else if (rd_en && hit_cnt_hi && (coh == TMC_COH_IDLE)) begin
         coh <= TMC_COH_HELD;
      end else if (rd_en && hit_cnt_lo) begin
         coh <= TMC_COH_IDLE;
      end
   end

   // latched low byte, only loaded on a fresh high read outside debug
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         cnt_lat <= `TMC_BYTE_ZERO;
      end else if (!HALTED_DEBUG_STATE_I && rd_en && hit_cnt_hi
                   && (coh == TMC_COH_IDLE)) begin
         cnt_lat <= snap[7:0];
      end
   end

   // read mux; a held low read returns the low byte latched at the high read
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (hit_sc) begin
         next_prdata[`TMC_SC_WRAP_BIT] = wrap_flag;
         next_prdata[`TMC_SC_CLK_HI:`TMC_SC_CLK_LO] = clock_source_select;
      end else if (hit_cnt_hi) begin
         next_prdata[7:0] = link.count[15:8];
      end else if (hit_cnt_lo) begin
         next_prdata[7:0] = (coh == TMC_COH_HELD) ? cnt_lat : link.count[7:0];
      end else if (hit_mod_hi) begin
         next_prdata[7:0] = link.mod[15:8];
      end else if (hit_mod_lo) begin
         next_prdata[7:0] = link.mod[7:0];
      end else begin
         next_err = !mapped;
      end
   end

   // read data and error registered in setup so they stand through the access cycle
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         PRDATA_O <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (setup) begin
         PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_prdata;
         err_q <= next_err;
      end
   end

   // status outputs
   assign COUNT_O = link.count;
   assign WRAP_FLAG_O = wrap_flag;
endmodule : tmc_top

// [shared/tmc_defines.svh]
// Purpose: offsets, field positions, reset values and limits of the timer modulo block
// Assumes: byte-wide registers, each on its own 32-bit aligned APB word
// Notes: definitions only, included by bare name
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// register byte addresses
`define TMC_OFF_SC 8'h00
`define TMC_OFF_CNT_HI 8'h04
`define TMC_OFF_CNT_LO 8'h08
`define TMC_OFF_MOD_HI 8'h0c
`define TMC_OFF_MOD_LO 8'h10

// status and control field positions
`define TMC_SC_WRAP_BIT 7
`define TMC_SC_CLK_HI 4
`define TMC_SC_CLK_LO 3

// reset values
`define TMC_MOD_RESET 16'h0000
`define TMC_CNT_RESET 16'h0000
`define TMC_CLK_RESET 2'b00
`define TMC_BYTE_ZERO 8'h00

// free-running limits used when the modulo value is zero
`define TMC_FREE_TOP 16'hffff
`define TMC_FREE_LOAD 16'hfffe

`endif

// [shared/tmc_pkg.sv]
// Purpose: shared types of the timer modulo block
// Assumes: used by the top module and its two leaves
// Notes: numeric constants live in tmc_defines.svh
package tmc_pkg;

   // one 16-bit counter or modulo word
   typedef logic [15:0] tmc_word_t;

   // one register byte
   typedef logic [7:0] tmc_byte_t;

   // counter read coherency state
   typedef enum logic [0:0] {
      TMC_COH_IDLE = 1'b0,
      TMC_COH_HELD = 1'b1
   } tmc_coh_t;

   // clock source selection, zero means no clock
   typedef enum logic [1:0] {
      TMC_CLK_OFF = 2'b00,
      TMC_CLK_SRC1 = 2'b01,
      TMC_CLK_SRC2 = 2'b10,
      TMC_CLK_SRC3 = 2'b11
   } tmc_clksel_t;

endpackage : tmc_pkg

// [shared/tmc_if.sv]
// Purpose: carrier between the register front end, the counter and the modulo buffer
// Assumes: single clock domain, all signals synchronous
// Notes: ctl modport is the front end
`timescale 1ns/1ns
interface tmc_if;
   import tmc_pkg::*;

   // counter side
   logic step;
   logic cnt_clear;
   tmc_word_t count;
   logic wrap_evt;
   logic load_pt;

   // modulo buffer side
   logic wr_hi;
   logic wr_lo;
   tmc_byte_t wdata;
   logic sc_wr;
   logic debug;
   logic clk_on;
   tmc_word_t mod;
   logic inhibit;

   modport ctl (
      output step, cnt_clear, wr_hi, wr_lo, wdata, sc_wr, debug, clk_on,
      input count, wrap_evt, mod, inhibit
   );

   modport cnt (
      input step, cnt_clear, mod,
      output count, wrap_evt, load_pt
   );

   modport modb (
      input wr_hi, wr_lo, wdata, sc_wr, debug, clk_on, load_pt,
      output mod, inhibit
   );
endinterface : tmc_if

// [verilog/tmc_counter.sv]
// Purpose: 16-bit up counter that wraps at the modulo value
// Assumes: step is already gated by clock selection and debug halt
// Notes: a zero modulo value means the full 16-bit range
`timescale 1ns/1ns
`include "tmc_defines.svh"
module tmc_counter (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // carrier
   tmc_if.cnt bus
);
   import tmc_pkg::*;

   tmc_word_t top;
   tmc_word_t next_count;

   // terminal count, zero modulo runs free
   assign top = (bus.mod == `TMC_MOD_RESET) ? `TMC_FREE_TOP : bus.mod;

   // wrap to zero after the terminal count
   assign next_count = (bus.count == top) ? `TMC_CNT_RESET : bus.count + 16'h0001;

   // buffered modulo lands as the counter steps onto the old terminal value
   assign bus.load_pt = bus.step && (bus.count == top - 16'h0001);

   // counter register
   always_ff @(posedge clk_i) begin
      if (srst_i || bus.cnt_clear) begin
         bus.count <= `TMC_CNT_RESET;
      end else if (bus.step) begin
         bus.count <= next_count;
      end
   end

   // one-cycle wrap event
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus.wrap_evt <= 1'b0;
      end else begin
         bus.wrap_evt <= bus.step && !bus.cnt_clear && (bus.count == top);
      end
   end
endmodule : tmc_counter

// [verilog/tmc_modbuf.sv]
// Purpose: modulo value with byte write buffer and deferred load
// Assumes: write strobes are single-cycle pulses from the register front end
// Notes: while halted the buffer latches hold unless a status write clears them, and writes go straight to the modulo
`timescale 1ns/1ns
`include "tmc_defines.svh"
module tmc_modbuf (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // carrier
   tmc_if.modb bus
);
   import tmc_pkg::*;

   tmc_byte_t buf_hi;
   tmc_byte_t buf_lo;
   logic got_hi;
   logic got_lo;
   logic both;

   // both halves present once this cycle's write is counted
   assign both = (got_hi || bus.wr_hi) && (got_lo || bus.wr_lo);

   // half-written modulo hides the wrap flag
   assign bus.inhibit = got_hi ^ got_lo;

   // byte buffers, untouched while halted
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         buf_hi <= `TMC_BYTE_ZERO;
         buf_lo <= `TMC_BYTE_ZERO;
      end else if (!bus.debug) begin
         if (bus.wr_hi) begin
            buf_hi <= bus.wdata;
         end
         if (bus.wr_lo) begin
            buf_lo <= bus.wdata;
         end
      end
   end

   // latch flags: status write clears them even when halted
   always_ff @(posedge clk_i) begin
      if (srst_i || bus.sc_wr) begin
         got_hi <= 1'b0;
         got_lo <= 1'b0;
      end else if (bus.debug) begin
         got_hi <= got_hi;
         got_lo <= got_lo;
      end else if (both && !bus.clk_on) begin
         got_hi <= 1'b0;
         got_lo <= 1'b0;
      end else if (got_hi && got_lo && bus.load_pt) begin
         // a byte written in the load cycle is kept as the start of the next pair
         got_hi <= bus.wr_hi;
         got_lo <= bus.wr_lo;
      end else begin
         got_hi <= got_hi || bus.wr_hi;
         got_lo <= got_lo || bus.wr_lo;
      end
   end

   // modulo register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus.mod <= `TMC_MOD_RESET;
      end else if (bus.debug) begin
         // halted writes bypass the buffer
         if (bus.wr_hi) begin
            bus.mod[15:8] <= bus.wdata;
         end
         if (bus.wr_lo) begin
            bus.mod[7:0] <= bus.wdata;
         end
      end else if (!bus.sc_wr && both && !bus.clk_on) begin
         // no clock: take the pair as soon as it is complete
         bus.mod <= {bus.wr_hi ? bus.wdata : buf_hi, bus.wr_lo ? bus.wdata : buf_lo};
      end else if (!bus.sc_wr && got_hi && got_lo && bus.load_pt) begin
         bus.mod <= {buf_hi, buf_lo};
      end
   end
endmodule : tmc_modbuf

// [tb/tmc_top_properties.sv]
// Purpose: port-level checks of the timer modulo block
// Assumes: one clock domain; status write bits 4:3 pick the clock source
// Notes: byte latch state is mirrored here, it is not visible at the ports
`timescale 1ns/1ns
`include "tmc_defines.svh"
module tmc_top_properties (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // timer
   input wire logic TIMER_TICK_I,
   input wire logic HALTED_DEBUG_STATE_I,
   input wire tmc_pkg::tmc_word_t COUNT_O,
   input wire logic WRAP_FLAG_O
);
   import tmc_pkg::*;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   logic acc, wr_sc, wr_cnt, run, hi_w, lo_w, pend;
   logic [1:0] csel;
   // access-phase decode; a write lands at this edge
   assign acc = PSEL_I && PENABLE_I;
   assign wr_sc = acc && PWRITE_I && PADDR_I == `TMC_OFF_SC;
   assign wr_cnt = acc && PWRITE_I && PADDR_I inside {`TMC_OFF_CNT_HI, `TMC_OFF_CNT_LO};
   assign run = TIMER_TICK_I && !HALTED_DEBUG_STATE_I && csel != 2'b00 && !wr_cnt;
   assign pend = hi_w ^ lo_w;
   // clock select mirror
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         csel <= 2'b00;
      end else if (wr_sc) begin
         csel <= PWDATA_I[4:3];
      end
   end
   // byte latch mirror; while halted only a status write clears it, so debug modulo writes leave it alone
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I || wr_sc) begin
         hi_w <= 1'b0;
         lo_w <= 1'b0;
      end else if (acc && PWRITE_I && !HALTED_DEBUG_STATE_I) begin
         if (PADDR_I == `TMC_OFF_MOD_HI) begin
            hi_w <= !lo_w;
            lo_w <= 1'b0;
         end else if (PADDR_I == `TMC_OFF_MOD_LO) begin
            lo_w <= !hi_w;
            hi_w <= 1'b0;
         end
      end
   end
   // a modulo wrap; the free-run rollover is left out, it is not a modulo match
   sequence s_wrap;
      run && !pend && COUNT_O != 16'h0 && COUNT_O != `TMC_FREE_TOP ##1 COUNT_O == 16'h0;
   endsequence
   sequence s_pend3;
      (pend && !WRAP_FLAG_O) [*3] ##1 pend;
   endsequence
   property p_hold;
      (!TIMER_TICK_I || csel == 2'b00) && !wr_cnt |=> $stable(COUNT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without a tick");
   property p_halt;
      HALTED_DEBUG_STATE_I |=> $stable(COUNT_O);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved while halted");
   property p_step;
      run |=> COUNT_O == $past(COUNT_O) + 16'h1 || COUNT_O == 16'h0;
   endproperty
   a_step: assert property (p_step) else $error("count did not step by one");
   property p_full;
      run && COUNT_O == `TMC_FREE_TOP |=> COUNT_O == 16'h0;
   endproperty
   a_full: assert property (p_full) else $error("count did not roll over at top");
   property p_wrap;
      s_wrap |-> ##[1:2] WRAP_FLAG_O;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap flag not set");
   property p_inhibit;
      s_pend3 |-> !WRAP_FLAG_O;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("wrap flag set with half pair");
   property p_err;
      acc |-> PSLVERR_O == !(PADDR_I inside {`TMC_OFF_SC, `TMC_OFF_CNT_HI, `TMC_OFF_CNT_LO,
         `TMC_OFF_MOD_HI, `TMC_OFF_MOD_LO});
   endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_rdhi;
      acc && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0;
   endproperty
   a_rdhi: assert property (p_rdhi) else $error("read data above byte not zero");
   property p_ready;
      acc |-> PREADY_O;
   endproperty
   a_ready: assert property (p_ready) else $error("access cycle not ready");
endmodule : tmc_top_properties

bind tmc_top tmc_top_properties u_props (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .TIMER_TICK_I(TIMER_TICK_I), .HALTED_DEBUG_STATE_I(HALTED_DEBUG_STATE_I),
   .COUNT_O(COUNT_O), .WRAP_FLAG_O(WRAP_FLAG_O));

// [tb/testbench.sv]
// Purpose: self-checking bench of the timer modulo block
// Assumes: reads are checked from a queue of expected bytes
// Notes: the free-run case walks the whole 16-bit range, about 66k cycles
`timescale 1ns/1ns
`include "tmc_defines.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module testbench;
   import tmc_pkg::*;
   localparam logic [7:0] a_sc = `TMC_OFF_SC;
   localparam logic [7:0] a_ch = `TMC_OFF_CNT_HI;
   localparam logic [7:0] a_cl = `TMC_OFF_CNT_LO;
   localparam logic [7:0] a_mh = `TMC_OFF_MOD_HI;
   localparam logic [7:0] a_ml = `TMC_OFF_MOD_LO;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, tick = 0, halt = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, exp_v;
   logic prdy, perr, wflag;
   tmc_word_t cnt;
   logic [15:0] r;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   logic [31:0] q[$];
   tmc_top u_dut (.REF_CLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .TIMER_TICK_I(tick), .HALTED_DEBUG_STATE_I(halt), .COUNT_O(cnt),
      .WRAP_FLAG_O(wflag));
   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic summarize;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // watcher: each finished read takes the oldest expectation; also cuts a hang
   always @(posedge clk) begin
      cyc++;
      if (psel && pen && !pwr && prdy === 1'b1 && q.size() > 0) begin
         exp_v = q.pop_front();
         `CHK(prd, exp_v)
      end
      if (cyc == 90000) begin
         error_cnt++;
         summarize();
      end
   end
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      q.push_back({24'h0, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   // split count read, high byte first
   task automatic rdc(input logic [15:0] v);
      rd(a_ch, v[15:8]);
      rd(a_cl, v[7:0]);
   endtask : rdc
   // n ticks back to back, then two idle edges so the wrap flag can land
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
      end
      @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : tk
   initial begin
      void'($urandom(65));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(a_mh, 8'h00);
      rd(a_ml, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h24, 8'h5a);
      // clock off: the pair lands on the second byte
      repeat (3) begin
         r = 16'($urandom);
         wr(a_mh, r[15:8]);
         wr(a_ml, r[7:0]);
         rd(a_mh, r[15:8]);
         rd(a_ml, r[7:0]);
      end
      wr(a_mh, 8'h00);
      wr(a_ml, 8'h05);
      tk(3);
      rdc(16'h0);
      wr(a_sc, 8'h08);
      tk(5);
      rdc(16'h5);
      tk(1);
      rdc(16'h0);
      rd(a_sc, 8'h88);
      wr(a_sc, 8'h08);
      // clock on: 3 must wait until the count reaches the old modulo
      wr(a_mh, 8'h00);
      wr(a_ml, 8'h03);
      tk(6);
      rdc(16'h6);
      wr(a_ch, 8'h00);
      tk(3);
      rdc(16'h3);
      tk(1);
      rdc(16'h0);
      // free run: the pending pair lands at the last step
      wr(a_sc, 8'h00);
      wr(a_mh, 8'h00);
      wr(a_ml, 8'h00);
      wr(a_sc, 8'h18);
      wr(a_ch, 8'h00);
      wr(a_mh, 8'h00);
      wr(a_ml, 8'h10);
      tk(65535);
      rdc(16'hffff);
      tk(18);
      rdc(16'h0);
      // half a pair holds the wrap flag back
      wr(a_sc, 8'h08);
      wr(a_mh, 8'h00);
      tk(17);
      rd(a_sc, 8'h08);
      wr(a_ml, 8'h10);
      tk(17);
      rd(a_sc, 8'h88);
      // status write drops a half pair
      wr(a_sc, 8'h00);
      wr(a_mh, 8'h00);
      wr(a_sc, 8'h00);
      wr(a_ml, 8'h07);
      wr(a_sc, 8'h10);
      wr(a_ch, 8'h00);
      tk(16);
      rdc(16'h10);
      // halted: frozen count and held low-byte latch
      tk(6);
      rd(a_ch, 8'h00);
      tk(2);
      @(posedge clk);
      halt <= 1'b1;
      tk(3);
      rd(a_cl, 8'h05);
      rd(a_cl, 8'h05);
      @(posedge clk);
      halt <= 1'b0;
      rd(a_cl, 8'h05);
      rd(a_cl, 8'h07);
      // halted writes: coherency reset, direct modulo, latch kept
      rd(a_ch, 8'h00);
      tk(2);
      wr(a_mh, 8'h00);
      @(posedge clk);
      halt <= 1'b1;
      wr(a_cl, 8'h00);
      wr(a_ml, 8'h06);
      @(posedge clk);
      halt <= 1'b0;
      rd(a_cl, 8'h09);
      wr(a_ch, 8'h00);
      tk(6);
      rdc(16'h6);
      tk(1);
      rdc(16'h0);
      wr(a_ml, 8'h09);
      tk(9);
      rdc(16'h9);
      tk(1);
      rdc(16'h0);
      summarize();
   end
endmodule : testbench
